// ===== hw/syn_pkg.sv
package syn_pkg;

   // Register offsets on the serial bus
   localparam logic [7:0] OFF_LOW  = 8'h00;
   localparam logic [7:0] OFF_HIGH = 8'h01;
   localparam logic [7:0] OFF_CMD  = 8'hf0;

   // Command codes, low nibble only
   localparam logic [3:0] CMD_INC       = 4'h1;
   localparam logic [3:0] CMD_STEP_DOWN = 4'h2;
   localparam logic [3:0] CMD_LOAD      = 4'h4;
   localparam logic [3:0] CMD_GET       = 4'h8;

   // High register field positions
   localparam int HI_FB_MSB   = 7;
   localparam int HI_FB_LSB   = 6;
   localparam int HI_POST_MSB = 5;
   localparam int HI_POST_LSB = 3;
   localparam int HI_HALF_BIT = 2;
   localparam int HI_PRE_BIT  = 1;
   localparam int HI_LOCK_BIT = 0;

   // Slave address prefix, followed by two select pins
   localparam logic [4:0] SLAVE_PREFIX = 5'h16;

   // Divider values held until the startup capture
   localparam logic [9:0] RST_FB   = 10'h1f4;
   localparam logic [2:0] RST_POST = 3'h2;
   localparam logic       RST_HALF = 1'b0;
   localparam logic       RST_PRE  = 1'b1;

   // Startup capture waits for the pin synchronisers to fill
   localparam logic [1:0] BOOT_CAP  = 2'h2;
   localparam logic [1:0] BOOT_DONE = 2'h3;

   // Bits in one serial byte
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_REG,
      ST_DATA,
      ST_READ,
      ST_MACK
   } syn_state_e_t;

endpackage : syn_pkg

// ===== hw/syn_sync.sv
`timescale 1ns/10ps

module syn_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // Asynchronous level in, synchronised level out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } syn_sync_t;

   syn_sync_t r;
   syn_sync_t next_r;

   always_comb begin
      next_r      = r;
      next_r.meta = d;
      next_r.sync = r.meta;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   assign q = r.sync;

endmodule : syn_sync

// ===== hw/syn_cfg_regs.sv
`timescale 1ns/10ps

module syn_cfg_regs (
   // Clock, master reset, clock enable
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   // Serial bus, open drain data
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic [1:0] addr_select,
   // Mode and status pins
   input  wire logic       parallel_mode_select_n,
   input  wire logic       lock_pin,
   // Parallel configuration pins
   input  wire logic [9:0] feedback_pins,
   input  wire logic [2:0] output_a_post_divider,
   input  wire logic       output_b_half_select,
   input  wire logic       pre_divider_select,
   // Active divider settings to the synthesizer
   output logic      [9:0] active_feedback,
   output logic      [2:0] active_post_a,
   output logic            active_half_b,
   output logic            active_pre
);

   typedef struct packed {
      logic                  scl_q;
      logic                  sda_q;
      syn_pkg::syn_state_e_t state;
      logic                  in_ack;
      logic [3:0]            cnt;
      logic [7:0]            shift;
      logic                  rw;
      logic [7:0]            reg_addr;
      logic [7:0]            tx;
      logic                  rd_high;
      logic                  sda_drive;
      logic [7:0]            low;
      logic [6:0]            high;
      logic [9:0]            fb;
      logic [2:0]            post_a;
      logic                  half_b;
      logic                  pre;
      logic [1:0]            boot;
   } syn_regs_t;

   syn_regs_t   r;
   syn_regs_t   next_r;

   logic [14:0] cfg_s;
   logic [5:0]  ctl_s;
   logic        scl_s;
   logic        sda_s;
   logic        mode_s;
   logic        lock_s;
   logic [1:0]  adr_s;
   logic [9:0]  pin_fb;
   logic [2:0]  pin_post;
   logic        pin_half;
   logic        pin_pre;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic [7:0]  low_byte;
   logic [7:0]  high_byte;
   logic [6:0]  live_high;
   logic        data_done;
   logic        wr_stb;
   logic        cmd_inc;
   logic        cmd_step_down;
   logic        cmd_load;
   logic        cmd_get;
   logic        addr_hit;

   // Every pin crosses two flops before use
   syn_sync #(.WIDTH(15)) u_cfg_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .d       ({feedback_pins, output_a_post_divider,
                 output_b_half_select, pre_divider_select}),
      .q       (cfg_s)
   );

   syn_sync #(.WIDTH(6)) u_ctl_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .d       ({scl, sda_in, parallel_mode_select_n, lock_pin,
                 addr_select}),
      .q       (ctl_s)
   );

   assign {pin_fb, pin_post, pin_half, pin_pre} = cfg_s;
   assign {scl_s, sda_s, mode_s, lock_s, adr_s} = ctl_s;

   // Bus events from the synchronised levels
   assign scl_rise = scl_s & ~r.scl_q;
   assign scl_fall = ~scl_s & r.scl_q;
   assign start_c  = scl_s & r.scl_q & r.sda_q & ~sda_s;
   assign stop_c   = scl_s & r.scl_q & ~r.sda_q & sda_s;

   assign addr_hit = (r.shift[7:1] == {syn_pkg::SLAVE_PREFIX, adr_s});

   // Lock is never stored, only mirrored
   assign low_byte  = r.low;
   assign high_byte = {r.high, lock_s};
   assign live_high = {r.fb[9:8], r.post_a, r.half_b, r.pre};

   always_comb begin
      next_r    = r;
      data_done = 1'b0;
      wr_stb    = 1'b0;
      cmd_inc   = 1'b0;
      cmd_step_down = 1'b0;
      cmd_load  = 1'b0;
      cmd_get   = 1'b0;

      next_r.scl_q = scl_s;
      next_r.sda_q = sda_s;

      // Bus protocol; start and stop override any bit phase
      if (start_c) begin
         next_r.state     = syn_pkg::ST_ADDR;
         next_r.cnt       = '0;
         next_r.in_ack    = 1'b0;
         next_r.sda_drive = 1'b0;
      end else if (stop_c) begin
         next_r.state     = syn_pkg::ST_IDLE;
         next_r.in_ack    = 1'b0;
         next_r.sda_drive = 1'b0;
      end else if (scl_rise) begin
         case (r.state)
            syn_pkg::ST_ADDR, syn_pkg::ST_REG, syn_pkg::ST_DATA: begin
               if (!r.in_ack) begin
                  next_r.shift = {r.shift[6:0], sda_s};
                  next_r.cnt   = 4'(r.cnt + 4'h1);
               end
            end
            syn_pkg::ST_READ: begin
               next_r.cnt = 4'(r.cnt + 4'h1);
            end
            syn_pkg::ST_MACK: begin
               // Master nack ends the read
               if (sda_s) begin
                  next_r.state = syn_pkg::ST_IDLE;
               end else begin
                  next_r.state   = syn_pkg::ST_READ;
                  next_r.cnt     = '0;
                  next_r.tx      = r.rd_high ? high_byte : low_byte;
                  next_r.rd_high = ~r.rd_high;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         if (r.in_ack) begin
            next_r.in_ack    = 1'b0;
            next_r.sda_drive = 1'b0;
            next_r.cnt       = '0;
            case (r.state)
               syn_pkg::ST_ADDR: begin
                  if (r.rw) begin
                     // Data follows the address byte at once
                     next_r.state     = syn_pkg::ST_READ;
                     next_r.tx        = low_byte;
                     next_r.rd_high   = 1'b1;
                     next_r.sda_drive = ~low_byte[7];
                  end else begin
                     next_r.state = syn_pkg::ST_REG;
                  end
               end
               syn_pkg::ST_REG: begin
                  next_r.state = syn_pkg::ST_DATA;
               end
               syn_pkg::ST_DATA: begin
                  next_r.state = syn_pkg::ST_REG;
               end
               default: begin
               end
            endcase
         end else if (r.cnt == syn_pkg::BYTE_BITS) begin
            case (r.state)
               syn_pkg::ST_ADDR: begin
                  if (addr_hit) begin
                     next_r.in_ack    = 1'b1;
                     next_r.sda_drive = 1'b1;
                     next_r.rw        = r.shift[0];
                  end else begin
                     next_r.state = syn_pkg::ST_IDLE;
                  end
               end
               syn_pkg::ST_REG: begin
                  next_r.reg_addr  = r.shift;
                  next_r.in_ack    = 1'b1;
                  next_r.sda_drive = 1'b1;
               end
               syn_pkg::ST_DATA: begin
                  next_r.in_ack    = 1'b1;
                  next_r.sda_drive = 1'b1;
                  data_done        = 1'b1;
               end
               syn_pkg::ST_READ: begin
                  next_r.sda_drive = 1'b0;
                  next_r.state     = syn_pkg::ST_MACK;
               end
               default: begin
               end
            endcase
         end else if (r.state == syn_pkg::ST_READ) begin
            next_r.sda_drive = ~r.tx[3'(3'h7 - r.cnt[2:0])];
         end
      end

      // Writes only take hold in serial mode
      wr_stb = data_done & mode_s;

      if (wr_stb) begin
         if (r.reg_addr == syn_pkg::OFF_LOW) begin
            next_r.low = r.shift;
         end else if (r.reg_addr == syn_pkg::OFF_HIGH) begin
            next_r.high = r.shift[7:syn_pkg::HI_PRE_BIT];
         end else if (r.reg_addr == syn_pkg::OFF_CMD) begin
            cmd_inc  = (r.shift[3:0] == syn_pkg::CMD_INC);
            cmd_step_down = (r.shift[3:0] == syn_pkg::CMD_STEP_DOWN);
            cmd_load = (r.shift[3:0] == syn_pkg::CMD_LOAD);
            cmd_get  = (r.shift[3:0] == syn_pkg::CMD_GET);
         end
      end

      // Steps wrap without bounds checks
      if (cmd_inc) begin
         next_r.fb = 10'(r.fb + 10'h001);
      end else if (cmd_step_down) begin
         next_r.fb = 10'(r.fb - 10'h001);
      end else if (cmd_load) begin
         next_r.fb     = {r.high[6:5], r.low};
         next_r.post_a = r.high[syn_pkg::HI_POST_MSB-1:
                                syn_pkg::HI_POST_LSB-1];
         next_r.half_b = r.high[syn_pkg::HI_HALF_BIT-1];
         next_r.pre    = r.high[syn_pkg::HI_PRE_BIT-1];
      end else if (cmd_get) begin
         next_r.low  = r.fb[7:0];
         next_r.high = live_high;
      end

      // Parallel mode and startup both load from the pins
      if (r.boot != syn_pkg::BOOT_DONE) begin
         next_r.boot = 2'(r.boot + 2'h1);
      end
      if ((r.boot == syn_pkg::BOOT_CAP) || (!mode_s && r.boot[1])) begin
         next_r.fb     = pin_fb;
         next_r.post_a = pin_post;
         next_r.half_b = pin_half;
         next_r.pre    = pin_pre;
         next_r.low    = pin_fb[7:0];
         next_r.high   = {pin_fb[9:8], pin_post, pin_half, pin_pre};
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         r          <= '0;
         r.scl_q    <= 1'b1;
         r.sda_q    <= 1'b1;
         r.state    <= syn_pkg::ST_IDLE;
         r.fb       <= syn_pkg::RST_FB;
         r.post_a   <= syn_pkg::RST_POST;
         r.half_b   <= syn_pkg::RST_HALF;
         r.pre      <= syn_pkg::RST_PRE;
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out         = 1'b0;
   assign sda_oe_n        = ~r.sda_drive;
   assign active_feedback = r.fb;
   assign active_post_a   = r.post_a;
   assign active_half_b   = r.half_b;
   assign active_pre      = r.pre;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_boot_capture: assert property (
      (clk_en && r.boot == syn_pkg::BOOT_CAP) |=> r.fb == $past(pin_fb))
      else $error("startup capture missed pins");

   a_pins_follow: assert property (
      (clk_en && !mode_s && r.boot[1]) |=> (r.fb == $past(pin_fb))
         && (r.post_a == $past(pin_post)))
      else $error("dividers not following pins");

   a_regs_track: assert property (
      (clk_en && !mode_s && r.boot[1]) |=> (r.low == $past(pin_fb[7:0]))
         && (r.high[0] == $past(pin_pre)))
      else $error("registers not tracking pins");

   a_stage_only: assert property (
      (clk_en && mode_s && wr_stb && r.reg_addr != syn_pkg::OFF_CMD
         && r.boot == syn_pkg::BOOT_DONE) |=> $stable(r.fb))
      else $error("register write moved dividers");

   a_step_up: assert property (
      (clk_en && cmd_inc && mode_s && r.boot == syn_pkg::BOOT_DONE)
         |=> (r.fb == 10'($past(r.fb) + 10'h001)) && $stable(r.low))
      else $error("increment wrong");

   a_step_down: assert property (
      (clk_en && cmd_step_down && mode_s && r.boot == syn_pkg::BOOT_DONE)
         |=> (r.fb == 10'($past(r.fb) - 10'h001)) && $stable(r.post_a)
         && $stable(r.pre))
      else $error("decrement wrong");

   a_load_apply: assert property (
      (clk_en && cmd_load && mode_s && r.boot == syn_pkg::BOOT_DONE)
         |=> r.fb == {$past(r.high[6:5]), $past(r.low)})
      else $error("apply did not copy registers");

   a_par_discard: assert property (
      (clk_en && data_done && !mode_s && r.boot[1]) |=> (r.low == r.fb[7:0])
         && (r.high == {r.fb[9:8], r.post_a, r.half_b, r.pre}))
      else $error("write taken in parallel mode");

   a_addr_ack: assert property (
      (clk_en && scl_fall && !start_c && !stop_c && !r.in_ack
         && r.state == syn_pkg::ST_ADDR
         && r.cnt == syn_pkg::BYTE_BITS && addr_hit) |=> !sda_oe_n)
      else $error("own address not acknowledged");

endmodule : syn_cfg_regs

// ===== bench/syn_host.sv
`timescale 1ns/10ps

// Bus master model; idles with SCL high and SDA released
module syn_host (
   // Core clock paces every bus edge
   input  wire logic mclk,
   // Bus pins, SDA pulled low only while sda_pull is high
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda_line
);

   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick

   // Data moves mid-low so SCL high always sees a settled line
   task automatic put_bit(input logic b);
      scl <= 1'b0;
      tick(2);
      sda_pull <= ~b;
      tick(3);
      scl <= 1'b1;
      tick(5);
   endtask : put_bit

   task automatic get_bit(output logic b);
      scl <= 1'b0;
      tick(2);
      sda_pull <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(2);
      b = sda_line;
      tick(3);
   endtask : get_bit

   task automatic start_cond;
      tick(5);
      sda_pull <= 1'b1;
      tick(5);
   endtask : start_cond

   task automatic stop_cond;
      scl <= 1'b0;
      tick(2);
      sda_pull <= 1'b1;
      tick(3);
      scl <= 1'b1;
      tick(5);
      sda_pull <= 1'b0;
      tick(5);
   endtask : stop_cond

   task automatic send(input logic [7:0] d, inout logic nak);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(a);
      nak = nak | a;
   endtask : send

   // Register address and data bytes in pairs, then stop
   task automatic write_seq(input logic [6:0] sla, input logic [7:0] b [4],
                            input int n, output logic nak);
      nak = 1'b0;
      start_cond();
      send({sla, 1'b0}, nak);
      for (int i = 0; i < n; i++) begin
         send(b[i], nak);
      end
      stop_cond();
   endtask : write_seq

   // Low byte acked, high byte refused so the device lets go
   task automatic read_regs(input logic [6:0] sla, output logic [7:0] lo,
                            output logic [7:0] hi, output logic nak);
      nak = 1'b0;
      start_cond();
      send({sla, 1'b1}, nak);
      for (int i = 7; i >= 0; i--) begin
         get_bit(lo[i]);
      end
      put_bit(1'b0);
      for (int i = 7; i >= 0; i--) begin
         get_bit(hi[i]);
      end
      put_bit(1'b1);
      stop_cond();
   endtask : read_regs

endmodule : syn_host

// ===== bench/testbench.sv
`timescale 1ns/10ps

module testbench;
   localparam logic [6:0] SLA = {syn_pkg::SLAVE_PREFIX, 2'b01};
   localparam logic [7:0] CMD = syn_pkg::OFF_CMD;
   logic       mclk, reset_n, scl, sda_pull, sda, sda_out, sda_oe_n;
   logic       mode_n, lock_pin, half_pin, pre_pin, act_half, act_pre, nak;
   logic [9:0] fb_pins, act_fb;
   logic [2:0] post_pins, act_post;
   logic [7:0] lo, hi;
   logic [1:0] adr;
   logic [7:0] b [4];
   int         n_errors  = 0;
   int         tests_run = 0;

   // Open drain line with pull-up
   assign sda = (sda_pull | (~sda_oe_n & ~sda_out)) ? 1'b0 : 1'b1;

   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   syn_cfg_regs syn_cfg_regs_inst (
      .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
      .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .addr_select(adr), .parallel_mode_select_n(mode_n),
      .lock_pin(lock_pin), .feedback_pins(fb_pins),
      .output_a_post_divider(post_pins), .output_b_half_select(half_pin),
      .pre_divider_select(pre_pin), .active_feedback(act_fb),
      .active_post_a(act_post), .active_half_b(act_half),
      .active_pre(act_pre)
   );

   syn_host syn_host_inst (
      .mclk(mclk), .scl(scl), .sda_pull(sda_pull), .sda_line(sda)
   );

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic chk_act(input logic [9:0] fb, input logic [2:0] p,
                          input logic h, input logic pr);
      check("active", 16'({act_fb, act_post, act_half, act_pre}),
            16'({fb, p, h, pr}));
   endtask : chk_act

   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      b[0] = r;
      b[1] = d;
      syn_host_inst.write_seq(SLA, b, 2, nak);
      check("write ack", 16'(nak), 16'h0000);
   endtask : wr

   task automatic rd_chk(input logic [7:0] el, input logic [7:0] eh);
      syn_host_inst.read_regs(SLA, lo, hi, nak);
      check("read ack", 16'(nak), 16'h0000);
      check("low reg", 16'(lo), 16'(el));
      check("high reg", 16'(hi), 16'(eh));
   endtask : rd_chk

   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   // Whole run is near 60 us; allow ample margin
   initial begin
      #500us;
      n_errors++;
      $display("Error watchdog expired");
      report_and_stop();
   end

   initial begin
      reset_n   = 1'b0;
      mode_n    = 1'b1;
      lock_pin  = 1'b1;
      adr       = 2'b01;
      fb_pins   = 10'h2a5;
      post_pins = 3'h5;
      half_pin  = 1'b1;
      pre_pin   = 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (8) @(posedge mclk);
      chk_act(10'h2a5, 3'h5, 1'b1, 1'b0);
      rd_chk(8'ha5, 8'had);
      $display("Test startup capture done");

      b = '{syn_pkg::OFF_LOW, 8'h3c, syn_pkg::OFF_HIGH, 8'h9b};
      syn_host_inst.write_seq(SLA, b, 4, nak);
      check("pair ack", 16'(nak), 16'h0000);
      chk_act(10'h2a5, 3'h5, 1'b1, 1'b0);
      lock_pin <= 1'b0;
      rd_chk(8'h3c, 8'h9a);
      wr(CMD, 8'ha4);
      chk_act(10'h23c, 3'h3, 1'b0, 1'b1);
      $display("Test staged apply done");

      wr(CMD, 8'h51);
      chk_act(10'h23d, 3'h3, 1'b0, 1'b1);
      wr(CMD, 8'h02);
      wr(CMD, 8'h02);
      chk_act(10'h23b, 3'h3, 1'b0, 1'b1);
      rd_chk(8'h3c, 8'h9a);
      wr(syn_pkg::OFF_LOW, 8'hff);
      wr(syn_pkg::OFF_HIGH, 8'hdb);
      wr(CMD, 8'h04);
      wr(CMD, 8'h01);
      chk_act(10'h000, 3'h3, 1'b0, 1'b1);
      wr(CMD, 8'h08);
      rd_chk(8'h00, 8'h1a);
      $display("Test steps and capture done");

      wr(CMD, 8'h03);
      wr(8'h05, 8'h77);
      chk_act(10'h000, 3'h3, 1'b0, 1'b1);
      rd_chk(8'h00, 8'h1a);
      syn_host_inst.write_seq(SLA ^ 7'h01, b, 0, nak);
      check("foreign address ack", 16'(nak), 16'h0001);
      // Select pins move the slave address
      adr <= 2'b10;
      repeat (4) @(posedge mclk);
      syn_host_inst.write_seq(SLA, b, 0, nak);
      check("old address ack", 16'(nak), 16'h0001);
      syn_host_inst.read_regs({syn_pkg::SLAVE_PREFIX, 2'b10}, lo, hi, nak);
      check("new address ack", 16'(nak), 16'h0000);
      check("new address low", 16'(lo), 16'h0000);
      check("new address high", 16'(hi), 16'h001a);
      adr <= 2'b01;
      repeat (4) @(posedge mclk);
      $display("Test ignored traffic done");

      // Mode only moves between transfers
      mode_n    <= 1'b0;
      fb_pins   <= 10'h155;
      post_pins <= 3'h6;
      half_pin  <= 1'b0;
      pre_pin   <= 1'b1;
      repeat (8) @(posedge mclk);
      chk_act(10'h155, 3'h6, 1'b0, 1'b1);
      fb_pins <= 10'h0f0;
      repeat (8) @(posedge mclk);
      chk_act(10'h0f0, 3'h6, 1'b0, 1'b1);
      wr(syn_pkg::OFF_LOW, 8'h11);
      wr(CMD, 8'h08);
      rd_chk(8'hf0, 8'h32);
      chk_act(10'h0f0, 3'h6, 1'b0, 1'b1);
      mode_n  <= 1'b1;
      fb_pins <= 10'h3aa;
      repeat (8) @(posedge mclk);
      chk_act(10'h0f0, 3'h6, 1'b0, 1'b1);
      rd_chk(8'hf0, 8'h32);
      $display("Test mode switching done");
      report_and_stop();
   end

endmodule : testbench
